// *** include/rst_seq_consts.svh ***
// Timing constants and functional notes for the reset sequencing logic
// Functional notes
// R1: Board holds external reset asserted at least 1 ms before release; the board model holds it 8 clocks.
// R2: External reset is asynchronous to the clock; synchronised internally before use.
// R3: Clock must run more than four periods while external reset is asserted.
// R4: External reset overrides a watchdog reset in progress; external exit timing applies.
// R5: External override leaves the watchdog reset-cause flag cleared.
// R6: Watchdog-only reset exits a fixed count of clocks after the timeout.
// R7: First instruction fetch starts about 6.5 clocks after external reset release.
// R8: Reset output is asserted whenever the device is being reset, any cause.
// R9: Reset output stays high two clocks after external reset deasserts.
// R10: First valid bus cycle starts about 4.5 clocks after external reset release.
// R11: Each of two UART channels picks processor or alternate serial clock independently.
// R12: Reset abandons activity and clears logic; execution starts at vector FFFF0h.
// R13: Internal reset synchroniser has two stages, async assert, sync release.
`ifndef RST_SEQ_CONSTS_SVH
`define RST_SEQ_CONSTS_SVH
`define CLK_PERIOD_NS     10
`define EXT_HOLD_MS       1
`define EXT_HOLD_CYC      ((`EXT_HOLD_MS * 1000000) / `CLK_PERIOD_NS)
`define SYNC_STAGES       2
`define OUT_HOLD_CYC      2
`define BUS_START_CYC     4
`define FETCH_START_CYC   6
`define WDOG_EXIT_CYC     65536
`define RESET_VECTOR      20'hFFFF0
`define CNT_W             17
`endif

// *** include/rst_seq_pkg.sv ***
// Types shared by the reset sequencing logic
package rst_seq_pkg;
  typedef enum logic [2:0] {ST_RUN, ST_EXT, ST_EXT_EXIT, ST_WDOG, ST_WDOG_EXIT} seq_e;
  typedef struct packed {
    logic        core_reset;
    logic        bus_enable;
    logic        fetch_enable;
    logic [19:0] fetch_addr;
  } cpu_ctl_s;
  typedef struct packed {
    logic ch0_use_alt;
    logic ch1_use_alt;
  } uart_sel_s;
endpackage

// *** core/rst_sync.sv ***
// Two-stage reset synchroniser, asynchronous assert and synchronous release
`timescale 1ns/100ps
module rst_sync (
  input  wire logic clk,        // System clock
  input  wire logic arst,       // Asynchronous reset, active high
  output logic      srst        // Synchronised reset, active high
);
  logic stage1_q;
  logic stage2_q;
  // First stage feeds only the second
  always_ff @(posedge clk or posedge arst) begin
    if (arst) begin
      stage1_q <= 1'b1; // R13
      stage2_q <= 1'b1;
    end else begin
      stage1_q <= 1'b0;
      stage2_q <= stage1_q; // R2 R13
    end
  end
  assign srst = stage2_q;
endmodule

// *** core/reset_sequencing_logic.sv ***
// Reset sequencer: external and watchdog reset arbitration and exit timing
`timescale 1ns/100ps
`include "rst_seq_consts.svh"
module reset_sequencing_logic (
  input  wire logic                   clk,                   // System clock, 100 MHz
  input  wire logic                   nrst,                  // Power-on reset, active low
  input  wire logic                   ext_reset_in,          // Board reset, active high, async
  input  wire logic                   wdog_timeout,          // Watchdog timeout pulse
  input  wire rst_seq_pkg::uart_sel_s uart_sel,              // Per-channel clock choice
  input  wire logic                   alt_serial_clock_in,   // Alternate serial clock
  output logic                        sys_reset_out,         // Reset to peripherals, high
  output logic                        wdog_reset_cause_flag, // Last reset was watchdog
  output rst_seq_pkg::cpu_ctl_s       cpu_ctl,               // Core reset/bus/fetch control
  output logic [1:0]                  uart_clk_sel           // Registered alt-clock selects
);
  import rst_seq_pkg::*;

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic n1_q, n2_q, rst_n;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      n1_q <= 1'b0;
      n2_q <= 1'b0;
    end else begin
      n1_q <= 1'b1;
      n2_q <= n1_q;
    end
  end
  assign rst_n = n2_q;

  logic ext_sync;
  rst_sync u_ext_sync (
    .clk  (clk),
    .arst (ext_reset_in),
    .srst (ext_sync)
  ); // R2 R13

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  seq_e             state_q;
  logic [`CNT_W-1:0] cnt_q;

  // Terminal count of the watchdog hold, shared by the sequencer and its checks
  function automatic logic wdog_done(input logic [`CNT_W-1:0] cnt);
    return cnt == `CNT_W'(`WDOG_EXIT_CYC - 1);
  endfunction

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_EXT;
      cnt_q   <= '0;
    end else begin
      unique case (state_q)
        ST_RUN: begin
          cnt_q <= '0;
          if (ext_sync) state_q <= ST_EXT;
          else if (wdog_timeout) state_q <= ST_WDOG;
        end
        ST_EXT: begin
          cnt_q <= '0;
          if (!ext_sync) state_q <= ST_EXT_EXIT;
        end
        ST_EXT_EXIT: begin
          if (ext_sync) begin
            state_q <= ST_EXT;
            cnt_q   <= '0;
          // Leave two edges early: the state step and the fetch flop each cost one
          end else if (cnt_q == `CNT_W'(`FETCH_START_CYC - `SYNC_STAGES - 2)) begin
            state_q <= ST_RUN; // R7
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        ST_WDOG: begin
          if (ext_sync) begin
            state_q <= ST_EXT; // R4
            cnt_q   <= '0;
          end else if (wdog_done(cnt_q)) begin
            state_q <= ST_WDOG_EXIT; // R6
            cnt_q   <= '0;
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        ST_WDOG_EXIT: begin
          cnt_q <= '0;
          if (ext_sync) state_q <= ST_EXT; // R4
          else state_q <= ST_RUN;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Sync delays release by two clocks, which also gives the output hold
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sys_reset_out <= 1'b1;
    end else begin
      sys_reset_out <= ext_sync || (state_q == ST_WDOG) ||
                       (state_q == ST_RUN && wdog_timeout); // R8 R9
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wdog_reset_cause_flag <= 1'b0;
    end else if (ext_sync) begin
      wdog_reset_cause_flag <= 1'b0; // R5
    end else if (state_q == ST_WDOG_EXIT) begin
      wdog_reset_cause_flag <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cpu_ctl <= '{core_reset: 1'b1, bus_enable: 1'b0, fetch_enable: 1'b0,
                   fetch_addr: `RESET_VECTOR};
    end else begin
      cpu_ctl.core_reset   <= (state_q != ST_RUN) || ext_sync; // R12
      cpu_ctl.bus_enable   <= (state_q == ST_RUN) ||
                              (state_q == ST_EXT_EXIT &&
                               cnt_q >= `CNT_W'(`BUS_START_CYC - `SYNC_STAGES - 1)); // R10
      cpu_ctl.fetch_enable <= (state_q == ST_RUN) && !ext_sync; // R7
      cpu_ctl.fetch_addr   <= `RESET_VECTOR; // R12
    end
  end

  // Plain per-channel selects; glitch-free muxing lives with the UARTs
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      uart_clk_sel <= 2'h0;
    end else begin
      uart_clk_sel <= {uart_sel.ch1_use_alt, uart_sel.ch0_use_alt}; // R11
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  ext_wins_a: assert property (@(posedge clk) disable iff (!rst_n) // R4
    (state_q == ST_WDOG && ext_sync) |=> state_q == ST_EXT)
    else $error("external reset did not override watchdog");
  flag_clear_a: assert property (@(posedge clk) disable iff (!rst_n) // R5
    ext_sync |=> !wdog_reset_cause_flag)
    else $error("cause flag set during external reset");
  out_hold_a: assert property (@(posedge clk) disable iff (!rst_n) // R9
    $fell(ext_sync) |-> sys_reset_out ##1 !sys_reset_out)
    else $error("reset out hold wrong");
  wdog_out_a: assert property (@(posedge clk) disable iff (!rst_n) // R8
    (state_q == ST_WDOG) |=> sys_reset_out)
    else $error("reset out low in watchdog reset");
  fetch_time_a: assert property (@(posedge clk) disable iff (!rst_n) // R7
    ($fell(ext_sync) && state_q == ST_EXT) |-> !cpu_ctl.fetch_enable [*5]
      ##1 cpu_ctl.fetch_enable)
    else $error("fetch start timing wrong");
  bus_time_a: assert property (@(posedge clk) disable iff (!rst_n) // R10
    ($fell(ext_sync) && state_q == ST_EXT) |-> !cpu_ctl.bus_enable [*3]
      ##1 cpu_ctl.bus_enable)
    else $error("bus start timing wrong");
  wdog_exit_a: assert property (@(posedge clk) disable iff (!rst_n) // R6
    (state_q == ST_WDOG && !ext_sync && wdog_done(cnt_q))
      |=> state_q == ST_WDOG_EXIT)
    else $error("watchdog exit count wrong");
  vector_a: assert property (@(posedge clk) disable iff (!rst_n) // R12
    $rose(cpu_ctl.fetch_enable) |-> cpu_ctl.fetch_addr == `RESET_VECTOR)
    else $error("fetch not from reset vector");

  // ----------------------------------------------------------------
  // Checks: entry into reset
  // ----------------------------------------------------------------
  wdog_entry_a: assert property (@(posedge clk) disable iff (!rst_n) // R8
    (state_q == ST_RUN && wdog_timeout && !ext_sync)
      |=> (sys_reset_out && state_q == ST_WDOG))
    else $error("watchdog timeout did not start a reset");
  ext_out_a: assert property (@(posedge clk) disable iff (!rst_n) // R8
    ext_sync |=> sys_reset_out)
    else $error("reset out low during external reset");
  ext_entry_a: assert property (@(posedge clk) disable iff (!rst_n) // R4
    ((state_q == ST_RUN || state_q == ST_WDOG_EXIT) && ext_sync)
      |=> state_q == ST_EXT)
    else $error("external reset not taken");
  exit_restart_a: assert property (@(posedge clk) disable iff (!rst_n) // R8
    (state_q == ST_EXT_EXIT && ext_sync) |=> state_q == ST_EXT)
    else $error("external reset during exit not taken");

  // ----------------------------------------------------------------
  // Checks: leaving reset
  // ----------------------------------------------------------------
  exit_low_a: assert property (@(posedge clk) disable iff (!rst_n) // R9
    (state_q == ST_EXT_EXIT && !ext_sync) |=> !sys_reset_out)
    else $error("reset out held past external exit");
  wdog_count_a: assert property (@(posedge clk) disable iff (!rst_n) // R6
    (state_q == ST_WDOG && !ext_sync && !wdog_done(cnt_q))
      |=> (state_q == ST_WDOG && cnt_q == $past(cnt_q) + 1'b1))
    else $error("watchdog hold counter did not advance");
  flag_set_a: assert property (@(posedge clk) disable iff (!rst_n) // R6
    (state_q == ST_WDOG_EXIT && !ext_sync) |=> wdog_reset_cause_flag)
    else $error("cause flag not set after watchdog reset");
  wdog_release_a: assert property (@(posedge clk) disable iff (!rst_n) // R6
    (state_q == ST_WDOG_EXIT && !ext_sync)
      |=> (!sys_reset_out && state_q == ST_RUN))
    else $error("watchdog reset not released");

  // ----------------------------------------------------------------
  // Checks: core control and clock selects
  // ----------------------------------------------------------------
  core_held_a: assert property (@(posedge clk) disable iff (!rst_n) // R12
    (state_q != ST_RUN) |=> cpu_ctl.core_reset)
    else $error("core released while in reset");
  fetch_idle_a: assert property (@(posedge clk) disable iff (!rst_n) // R12
    (state_q != ST_RUN) |=> !cpu_ctl.fetch_enable)
    else $error("fetch enabled while in reset");
  run_free_a: assert property (@(posedge clk) disable iff (!rst_n) // R12
    (state_q == ST_RUN && !ext_sync)
      |=> (!cpu_ctl.core_reset && cpu_ctl.fetch_enable))
    else $error("core not running after reset");
  bus_idle_a: assert property (@(posedge clk) disable iff (!rst_n) // R10
    (state_q == ST_EXT || state_q == ST_WDOG || state_q == ST_WDOG_EXIT)
      |=> !cpu_ctl.bus_enable)
    else $error("bus enabled while in reset");
  bus_order_a: assert property (@(posedge clk) disable iff (!rst_n) // R10
    cpu_ctl.fetch_enable |-> cpu_ctl.bus_enable)
    else $error("fetch enabled before bus");
  uart_sel_a: assert property (@(posedge clk) disable iff (!rst_n) // R11
    1'b1 |=> uart_clk_sel == {$past(uart_sel.ch1_use_alt), $past(uart_sel.ch0_use_alt)})
    else $error("uart clock select not registered");
endmodule

// *** verif/board_reset.sv ***
// Board reset circuit model driving the external reset pin
`timescale 1ns/100ps
module board_reset #(
  parameter int HOLD_CYC = 8
) (
  input  wire logic clk,          // System clock
  output logic      ext_reset_in  // Board reset, active high
);
  initial ext_reset_in = 1'b0;
  // Hold shortened from 1 ms so the run stays short; still above four clocks
  task automatic press();
    @(negedge clk);
    ext_reset_in = 1'b1;
    repeat (HOLD_CYC) @(negedge clk);
  endtask
  task automatic lift();
    ext_reset_in = 1'b0;
  endtask
endmodule

// *** verif/tb.sv ***
// Self-checking testbench for the reset sequencer
`timescale 1ns/100ps
module tb;
  import rst_seq_pkg::*;
  logic      clk = 1'b0;
  logic      nrst = 1'b0;
  logic      wdog_timeout = 1'b0;
  logic      alt_serial_clock_in = 1'b0;
  uart_sel_s uart_sel = '0;
  logic      ext_reset_in, sys_reset_out, wdog_reset_cause_flag;
  logic [1:0] uart_clk_sel;
  cpu_ctl_s  cpu_ctl;
  int        fail_count = 0;
  int        n_checks = 0;
  int        cyc = 0;
  always #5 clk = ~clk;
  always #35 alt_serial_clock_in = ~alt_serial_clock_in;
  board_reset #(.HOLD_CYC(8)) board_u (.clk(clk), .ext_reset_in(ext_reset_in));
  reset_sequencing_logic dut_u (
    .clk(clk), .nrst(nrst), .ext_reset_in(ext_reset_in), .wdog_timeout(wdog_timeout),
    .uart_sel(uart_sel), .alt_serial_clock_in(alt_serial_clock_in),
    .sys_reset_out(sys_reset_out), .wdog_reset_cause_flag(wdog_reset_cause_flag),
    .cpu_ctl(cpu_ctl), .uart_clk_sel(uart_clk_sel));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("checks=%0d mismatches=%0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 90000) begin
      fail_count++;
      finish_test();
    end
  end
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  // Edges from a falling-edge pin release to each exit step
  task automatic exit_timing();
    int t_out, t_bus, t_fetch;
    t_out = 0;
    t_bus = 0;
    t_fetch = 0;
    board_u.lift();
    for (int k = 1; k <= 12; k++) begin
      @(posedge clk);
      #1;
      if (t_out == 0 && sys_reset_out === 1'b0) t_out = k;
      if (t_bus == 0 && cpu_ctl.bus_enable === 1'b1) t_bus = k;
      if (t_fetch == 0 && cpu_ctl.fetch_enable === 1'b1) t_fetch = k;
    end
    check(t_out, 3);
    check(t_bus, 5);
    check(t_fetch, 7);
    check(cpu_ctl.fetch_addr, 20'hFFFF0);
    check(cpu_ctl.core_reset, 1'b0);
  endtask
  task automatic t_uart();
    uart_sel_s s;
    for (int i = 0; i < 4; i++) begin
      s = uart_sel_s'(i[1:0]);
      @(negedge clk) uart_sel = s;
      @(negedge clk) check(uart_clk_sel, {s.ch1_use_alt, s.ch0_use_alt});
    end
    $display("test uart done");
  endtask
  task automatic t_ext();
    board_u.press();
    check(sys_reset_out, 1'b1);
    check(cpu_ctl.core_reset, 1'b1);
    exit_timing();
    check(wdog_reset_cause_flag, 1'b0);
    $display("test ext done");
  endtask
  task automatic pulse_wdog();
    int n;
    n = 0;
    @(negedge clk) wdog_timeout = 1'b1;
    @(negedge clk) wdog_timeout = 1'b0;
    while (sys_reset_out !== 1'b1 && n < 4) begin
      @(posedge clk);
      #1;
      n++;
    end
    check(sys_reset_out, 1'b1);
  endtask
  task automatic t_wdog();
    int n;
    n = 0;
    pulse_wdog();
    while (sys_reset_out === 1'b1 && n < 70000) begin
      @(posedge clk);
      #1;
      n++;
    end
    check(n, 65537);
    repeat (10) @(negedge clk);
    check(wdog_reset_cause_flag, 1'b1);
    $display("test wdog done");
  endtask
  task automatic t_over();
    pulse_wdog();
    repeat (50) @(negedge clk);
    board_u.press();
    exit_timing();
    repeat (10) @(negedge clk);
    check(wdog_reset_cause_flag, 1'b0);
    $display("test override done");
  endtask
  initial begin
    repeat (16) @(negedge clk);
    nrst = 1'b1;
    repeat (20) @(negedge clk);
    t_uart();
    t_ext();
    t_wdog();
    t_over();
    finish_test();
  end
endmodule
